/* File: bench/dio_ext_model.sv */
`timescale 1ns/1ps
// Far-side equipment: drives a pin only when told, otherwise the line floats to its pull-up
module dio_ext_model (
	// Design side
	input wire logic [6:0] pin_o,
	input wire logic [6:0] pin_oe,
	// Bench control
	input wire logic [6:0] drv_en,
	input wire logic [6:0] drv_lvl,
	// Resolved wire
	output logic [6:0] pin_i
);
	// A pulse from this side is a low drive released back to the high idle level
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			pin_i[i] = pin_oe[i] ? pin_o[i] : (drv_en[i] ? drv_lvl[i] : 1'b1);
		end
	end
endmodule : dio_ext_model

/* File: bench/dio_port_tb.sv */
`timescale 1ns/1ps
module dio_port_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, prot = 1'b0, on = 1'b0;
	logic [6:0] pin_i, pin_o, pin_oe, drv_en = 7'h00, drv_lvl = 7'h7F;
	logic clr, trig, inh, son, soff;
	int err_count = 0;
	int tests_run = 0;
	int n;
	wire [3:0] ev = {soff, son, trig, clr};

	always #5 pclk = ~pclk;

	dio_port #(.PWM_PERIOD_DEF(32'h14), .PWM_ACTIVE_DEF(32'h2)) dut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe(pin_oe), .protection_flag_level(prot), .input_on(on),
		.protection_clear_pulse(clr), .trigger_pulse(trig), .emergency_inhibit(inh),
		.sync_on_pulse(son), .sync_off_pulse(soff));

	dio_ext_model ext (.pin_o(pin_o), .pin_oe(pin_oe), .drv_en(drv_en), .drv_lvl(drv_lvl),
		.pin_i(pin_i));

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk

	// Holds the request until pready is seen high; the wait is bounded
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
		int k;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready === 1'b1) begin
			rd = prdata;
			chk({31'h0, pslverr}, {31'h0, err}, "slave error");
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk(32'h0, 32'h1, "pready timeout");
			report_and_stop();
		end
	endtask : apb

	// Low pulse on one pin, expecting x events
	task pulse(input int p, input int e, input int x);
		n = 0;
		@(posedge pclk);
		drv_en[p] <= 1'b1;
		drv_lvl[p] <= 1'b0;
		repeat (10) begin
			@(negedge pclk);
			if (ev[e] === 1'b1) n++;
		end
		@(posedge pclk);
		drv_en[p] <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(32'(n), 32'(x), "event count");
	endtask : pulse

	task settle;
		repeat (6) @(negedge pclk);
	endtask : settle

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		chk({25'h0, pin_o}, 32'h7F, "reset drive");
		chk({25'h0, pin_oe}, 32'h6, "reset enable");
		apb(1'b0, dio_pkg::ADDR_ROLE, 32'h0, 1'b0);
		chk(rd, 32'h0, "reset roles");
		pulse(0, 0, 0);
		prot <= 1'b1;
		settle();
		chk({31'h0, pin_o[1]}, 32'h0, "protection level");
		chk({31'h0, pin_o[2]}, 32'h1, "on state level");
		apb(1'b0, dio_pkg::ADDR_STATUS, 32'h0, 1'b0);
		chk(rd, 32'h5, "status word");
		apb(1'b0, dio_pkg::ADDR_PWM_PERIOD, 32'h0, 1'b0);
		chk(rd, 32'h14, "pwm period");
		pulse(0, 0, 1);
		chk({31'h0, inh}, 32'h1, "inhibit idle high");
		@(posedge pclk);
		drv_en[4] <= 1'b1;
		drv_lvl[4] <= 1'b0;
		settle();
		chk({31'h0, inh}, 32'h0, "inhibit low");
		apb(1'b1, dio_pkg::ADDR_INVERT, 32'h10, 1'b0);
		settle();
		chk({31'h0, inh}, 32'h1, "inhibit inverted");
		apb(1'b1, dio_pkg::ADDR_INVERT, 32'h0, 1'b0);
		drv_en[4] <= 1'b0;
		pulse(5, 2, 1);
		pulse(6, 3, 1);
		pulse(3, 1, 0);
		apb(1'b1, dio_pkg::ADDR_CTRL, 32'h1, 1'b0);
		pulse(3, 1, 1);
		apb(1'b1, dio_pkg::ADDR_ROLE, 32'h1080, 1'b0);
		apb(1'b1, dio_pkg::ADDR_OUT_LEVEL, 32'h8, 1'b0);
		settle();
		chk({30'h0, pin_oe[3], pin_o[3]}, 32'h2, "output true");
		apb(1'b1, dio_pkg::ADDR_INVERT, 32'h8, 1'b0);
		settle();
		chk({31'h0, pin_o[3]}, 32'h1, "output inverted");
		@(posedge pclk);
		drv_en[6] <= 1'b1;
		drv_lvl[6] <= 1'b0;
		settle();
		apb(1'b0, dio_pkg::ADDR_IN_STATE, 32'h0, 1'b0);
		chk({31'h0, rd[6]}, 32'h0, "input state");
		apb(1'b1, dio_pkg::ADDR_INVERT, 32'h0, 1'b0);
		apb(1'b1, dio_pkg::ADDR_PWM_SEL, 32'h8, 1'b0);
		settle();
		n = 0;
		repeat (20) begin
			@(negedge pclk);
			if (pin_o[3] === 1'b0) n++;
		end
		chk(32'(n), 32'h2, "pwm low time");
		apb(1'b1, 8'h40, 32'h1, 1'b1);
		apb(1'b1, dio_pkg::ADDR_STATUS, 32'h1, 1'b1);
		prot <= 1'b0;
		repeat (2) @(posedge pclk);
		on <= 1'b1;
		n = 0;
		for (int c = 1; c <= dio_pkg::PULSE_CYC + 8; c++) begin
			@(negedge pclk);
			if (c == 4) chk({30'h0, pin_oe[0], pin_o[0]}, 32'h2, "clear pulse out");
			if (pin_oe[0] === 1'b1 && pin_o[0] === 1'b0) n++;
		end
		chk(32'(n), 32'(dio_pkg::PULSE_CYC), "clear pulse width");
		chk({30'h0, pin_oe[0], pin_o[0]}, 32'h1, "clear pulse released");
		report_and_stop();
	end
endmodule : dio_port_tb

/* File: include/dio_edge_if.sv */
`timescale 1ns/1ps
interface dio_edge_if;
	logic [6:0] invert;
	logic [6:0] level;
	logic [6:0] fall;

	modport sync (input invert, output level, output fall);
	modport user (output invert, input level, input fall);
endinterface : dio_edge_if

/* File: include/dio_pkg.sv */
package dio_pkg;
	localparam int NUM_PINS = 7;
	localparam int CLK_HZ = 100_000_000;

	// Pin positions, counted from zero
	localparam int PIN_PCLR = 0;
	localparam int PIN_PFLAG = 1;
	localparam int PIN_ONOFF = 2;
	localparam int PIN_TRIG = 3;
	localparam int PIN_INH = 4;
	localparam int PIN_SON = 5;
	localparam int PIN_SOFF = 6;

	// Outgoing clear pulse: least low time, counted in whole cycles (clock rate in MHz rounded down)
	localparam int PULSE_WIDTH_US = 30;
	localparam int PULSE_CYC = PULSE_WIDTH_US * (CLK_HZ / 1_000_000);
	localparam logic [15:0] PULSE_CNT_INIT = 16'(PULSE_CYC - 1);

	// PWM reset settings
	localparam int PWM_FREQ_HZ = 100;
	localparam int PWM_DUTY_PCT = 10;
	localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
	localparam int PWM_ACTIVE_CYC = (PWM_PERIOD_CYC / 100) * PWM_DUTY_PCT;

	// Register byte addresses
	localparam logic [7:0] ADDR_ROLE = 8'h00;
	localparam logic [7:0] ADDR_INVERT = 8'h04;
	localparam logic [7:0] ADDR_OUT_LEVEL = 8'h08;
	localparam logic [7:0] ADDR_PWM_SEL = 8'h0C;
	localparam logic [7:0] ADDR_PWM_PERIOD = 8'h10;
	localparam logic [7:0] ADDR_PWM_ACTIVE = 8'h14;
	localparam logic [7:0] ADDR_CTRL = 8'h18;
	localparam logic [7:0] ADDR_IN_STATE = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;

	// Reset values
	localparam logic [13:0] ROLE_RST = 14'h0000;
	localparam logic [6:0] PIN_O_RST = 7'h7F;
	localparam logic [6:0] PIN_OE_RST = 7'h06;

	typedef enum logic [1:0] {
		DIO_ROLE_DEFAULT = 2'h0,
		DIO_ROLE_INPUT = 2'h1,
		DIO_ROLE_OUTPUT = 2'h2
	} dio_role_t;

	typedef enum logic {
		DIO_P1_IDLE = 1'h0,
		DIO_P1_PULSE = 1'h1
	} dio_p1_state_t;

	// Code 3 is not a role; it falls back to the default role
	function automatic dio_role_t dio_role_of(input logic [13:0] roles, input int idx);
		logic [1:0] r;
		r = roles[2 * idx +: 2];
		case (r)
			2'h1: dio_role_of = DIO_ROLE_INPUT;
			2'h2: dio_role_of = DIO_ROLE_OUTPUT;
			default: dio_role_of = DIO_ROLE_DEFAULT;
		endcase
	endfunction : dio_role_of
endpackage : dio_pkg

/* File: src/dio_pin_sync.sv */
`timescale 1ns/1ps
module dio_pin_sync (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Raw pins
	input wire logic [6:0] pin_i,
	// Logical levels and edges
	dio_edge_if.sync edges
);
	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		logic [6:0] prev;
	} dio_sync_t;

	dio_sync_t s_q;
	dio_sync_t s_d;
	logic [6:0] logical;

	// Idle pins float high, so the stages start high
	always_comb begin
		s_d = s_q;
		s_d.s1 = pin_i;
		s_d.s2 = s_q.s1;
		s_d.prev = logical;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{s1: 7'h7F, s2: 7'h7F, prev: 7'h7F};
		end else begin
			s_q <= s_d;
		end
	end

	// Invert moves the valid level, so a pulse is always a logical high-to-low
	assign logical = s_q.s2 ^ edges.invert;
	assign edges.level = logical;
	assign edges.fall = s_q.prev & ~logical;

	a_fall_single: assert property (@(posedge pclk) disable iff (!presetn)
		(edges.fall != 7'h00) |=> ((edges.fall & $past(edges.fall)) == 7'h00))
		else $error("pin edge reported twice");
endmodule : dio_pin_sync

/* File: src/dio_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - Every pin: default role, input or output
// - Output true drives low, false high
// - Input pins sampled, state readable
// - PWM period and low time programmable
// - Per-pin invert swaps the valid level
// - Pulses are high-to-low edges
// - Pins 2,3 show protection and on state
// - Pin 5 inhibit forces input off
// - Inhibit valid high, low when inverted
// - Pins 6,7 pulses switch on, off
// - Pin 4 pulse triggers when external selected
// - Pin 1 pulse clears active protection
// - Pin 1 pulses after protected-free turn on
module dio_port #(
	parameter logic [31:0] PWM_PERIOD_DEF = 32'(dio_pkg::PWM_PERIOD_CYC),
	parameter logic [31:0] PWM_ACTIVE_DEF = 32'(dio_pkg::PWM_ACTIVE_CYC)
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port pins
	input wire logic [6:0] pin_i,
	output logic [6:0] pin_o,
	output logic [6:0] pin_oe,
	// Instrument state
	input wire logic protection_flag_level,
	input wire logic input_on,
	// Instrument events
	output logic protection_clear_pulse,
	output logic trigger_pulse,
	output logic emergency_inhibit,
	output logic sync_on_pulse,
	output logic sync_off_pulse
);
	typedef struct packed {
		logic [13:0] role;
		logic [6:0] inv;
		logic [6:0] lvl;
		logic [6:0] pwm_sel;
		logic [31:0] period;
		logic [31:0] active;
		logic trig_ext;
		logic [31:0] prdata;
		logic err;
		logic [31:0] pwm_cnt;
		dio_pkg::dio_p1_state_t p1_state;
		logic [15:0] p1_cnt;
		logic on_prev;
		logic [6:0] pin_o;
		logic [6:0] pin_oe;
		logic clr;
		logic trig;
		logic inh;
		logic son;
		logic soff;
	} dio_state_t;

	localparam dio_state_t RST = '{
		role: dio_pkg::ROLE_RST,
		inv: 7'h00,
		lvl: 7'h00,
		pwm_sel: 7'h00,
		period: PWM_PERIOD_DEF,
		active: PWM_ACTIVE_DEF,
		trig_ext: 1'h0,
		prdata: 32'h0000_0000,
		err: 1'h0,
		pwm_cnt: 32'h0000_0000,
		p1_state: dio_pkg::DIO_P1_IDLE,
		p1_cnt: 16'h0000,
		on_prev: 1'h0,
		pin_o: dio_pkg::PIN_O_RST,
		pin_oe: dio_pkg::PIN_OE_RST,
		clr: 1'h0,
		trig: 1'h0,
		inh: 1'h0,
		son: 1'h0,
		soff: 1'h0
	};

	dio_state_t s_q;
	dio_state_t s_d;
	dio_edge_if edges ();

	dio_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_i(pin_i),
		.edges(edges.sync)
	);

	assign edges.invert = s_q.inv;

	logic setup_ph;
	logic access_wr;
	logic pwm_on;
	logic p1_busy;
	logic on_rise;

	assign setup_ph = psel & ~penable;
	assign access_wr = psel & penable & pwrite;
	assign pwm_on = s_q.pwm_cnt < s_q.active;
	assign p1_busy = s_q.p1_state == dio_pkg::DIO_P1_PULSE;
	assign on_rise = input_on & ~s_q.on_prev & ~protection_flag_level;

	function automatic logic is_default(input logic [13:0] roles, input int idx);
		is_default = dio_pkg::dio_role_of(roles, idx) == dio_pkg::DIO_ROLE_DEFAULT;
	endfunction : is_default

	always_comb begin
		dio_pkg::dio_role_t r;
		logic act;
		r = dio_pkg::DIO_ROLE_DEFAULT;
		act = 1'b0;
		s_d = s_q;

		// Registers answer with no wait; data is latched in the setup cycle
		if (setup_ph) begin
			s_d.err = 1'b0;
			s_d.prdata = 32'h0000_0000;
			unique case (paddr)
				dio_pkg::ADDR_ROLE: s_d.prdata = {18'h00000, s_q.role};
				dio_pkg::ADDR_INVERT: s_d.prdata = {25'h0000000, s_q.inv};
				dio_pkg::ADDR_OUT_LEVEL: s_d.prdata = {25'h0000000, s_q.lvl};
				dio_pkg::ADDR_PWM_SEL: s_d.prdata = {25'h0000000, s_q.pwm_sel};
				dio_pkg::ADDR_PWM_PERIOD: s_d.prdata = s_q.period;
				dio_pkg::ADDR_PWM_ACTIVE: s_d.prdata = s_q.active;
				dio_pkg::ADDR_CTRL: s_d.prdata = {31'h00000000, s_q.trig_ext};
				dio_pkg::ADDR_IN_STATE: begin
					s_d.prdata = {25'h0000000, edges.level};
					s_d.err = pwrite;
				end
				dio_pkg::ADDR_STATUS: begin
					s_d.prdata = {28'h0000000, p1_busy, s_q.inh, input_on,
						protection_flag_level};
					s_d.err = pwrite;
				end
				default: s_d.err = 1'b1;
			endcase
			if (pwrite) begin
				s_d.prdata = 32'h0000_0000;
			end
		end

		if (access_wr && !s_q.err) begin
			unique case (paddr)
				dio_pkg::ADDR_ROLE: s_d.role = pwdata[13:0];
				dio_pkg::ADDR_INVERT: s_d.inv = pwdata[6:0];
				dio_pkg::ADDR_OUT_LEVEL: s_d.lvl = pwdata[6:0];
				dio_pkg::ADDR_PWM_SEL: s_d.pwm_sel = pwdata[6:0];
				dio_pkg::ADDR_PWM_PERIOD: s_d.period = pwdata;
				dio_pkg::ADDR_PWM_ACTIVE: s_d.active = pwdata;
				dio_pkg::ADDR_CTRL: s_d.trig_ext = pwdata[0];
				default: s_d.trig_ext = s_q.trig_ext;
			endcase
		end

		// Shared PWM timebase; a period of zero or one keeps the counter at zero
		if (s_q.pwm_cnt + 32'h0000_0001 >= s_q.period) begin
			s_d.pwm_cnt = 32'h0000_0000;
		end else begin
			s_d.pwm_cnt = s_q.pwm_cnt + 32'h0000_0001;
		end

		// Turn-on pulse on pin 1 when input_on rises while protection is low
		s_d.on_prev = input_on;
		unique case (s_q.p1_state)
			dio_pkg::DIO_P1_IDLE: begin
				if (on_rise && is_default(s_q.role, dio_pkg::PIN_PCLR)) begin
					s_d.p1_state = dio_pkg::DIO_P1_PULSE;
					s_d.p1_cnt = dio_pkg::PULSE_CNT_INIT;
				end
			end
			dio_pkg::DIO_P1_PULSE: begin
				if (s_q.p1_cnt == 16'h0000) begin
					s_d.p1_state = dio_pkg::DIO_P1_IDLE;
				end else begin
					s_d.p1_cnt = s_q.p1_cnt - 16'h0001;
				end
			end
		endcase

		for (int i = 0; i < dio_pkg::NUM_PINS; i++) begin
			r = dio_pkg::dio_role_of(s_q.role, i);
			unique case (r)
				dio_pkg::DIO_ROLE_INPUT: begin
					s_d.pin_oe[i] = 1'b0;
					s_d.pin_o[i] = 1'b1;
				end
				dio_pkg::DIO_ROLE_OUTPUT: begin
					act = s_q.pwm_sel[i] ? pwm_on : s_q.lvl[i];
					s_d.pin_oe[i] = 1'b1;
					s_d.pin_o[i] = ~act ^ s_q.inv[i];
				end
				dio_pkg::DIO_ROLE_DEFAULT: begin
					if (i == dio_pkg::PIN_PFLAG) begin
						act = protection_flag_level;
					end else if (i == dio_pkg::PIN_ONOFF) begin
						act = input_on;
					end else begin
						act = p1_busy && i == dio_pkg::PIN_PCLR;
					end
					s_d.pin_oe[i] = i == dio_pkg::PIN_PFLAG || i == dio_pkg::PIN_ONOFF
						|| (i == dio_pkg::PIN_PCLR && p1_busy);
					s_d.pin_o[i] = ~act ^ s_q.inv[i];
				end
			endcase
		end

		// Default-role input events; pin 1 ignores its own outgoing pulse
		s_d.clr = edges.fall[dio_pkg::PIN_PCLR] & protection_flag_level & ~p1_busy
			& is_default(s_q.role, dio_pkg::PIN_PCLR);
		s_d.trig = edges.fall[dio_pkg::PIN_TRIG] & s_q.trig_ext
			& is_default(s_q.role, dio_pkg::PIN_TRIG);
		s_d.inh = edges.level[dio_pkg::PIN_INH]
			& is_default(s_q.role, dio_pkg::PIN_INH);
		s_d.son = edges.fall[dio_pkg::PIN_SON]
			& is_default(s_q.role, dio_pkg::PIN_SON);
		s_d.soff = edges.fall[dio_pkg::PIN_SOFF]
			& is_default(s_q.role, dio_pkg::PIN_SOFF);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & s_q.err;
	assign pin_o = s_q.pin_o;
	assign pin_oe = s_q.pin_oe;
	assign protection_clear_pulse = s_q.clr;
	assign trigger_pulse = s_q.trig;
	assign emergency_inhibit = s_q.inh;
	assign sync_on_pulse = s_q.son;
	assign sync_off_pulse = s_q.soff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Role checks watch one pin each; input and output roles use the same logic on all seven pins
	a_input_no_drive: assert property (
		dio_pkg::dio_role_of(s_q.role, dio_pkg::PIN_SOFF) == dio_pkg::DIO_ROLE_INPUT
		|=> !pin_oe[dio_pkg::PIN_SOFF])
		else $error("input pin is driven");
	a_output_driven: assert property (
		dio_pkg::dio_role_of(s_q.role, dio_pkg::PIN_TRIG) == dio_pkg::DIO_ROLE_OUTPUT
		|=> pin_oe[dio_pkg::PIN_TRIG])
		else $error("output pin not driven");
	a_default_float: assert property (
		is_default(s_q.role, dio_pkg::PIN_INH) |=> !pin_oe[dio_pkg::PIN_INH])
		else $error("default input pin is driven");
	a_out_true_low: assert property (
		dio_pkg::dio_role_of(s_q.role, dio_pkg::PIN_TRIG) == dio_pkg::DIO_ROLE_OUTPUT
		&& !s_q.pwm_sel[dio_pkg::PIN_TRIG] && !s_q.inv[dio_pkg::PIN_TRIG]
		&& s_q.lvl[dio_pkg::PIN_TRIG]
		|=> pin_oe[dio_pkg::PIN_TRIG] && !pin_o[dio_pkg::PIN_TRIG])
		else $error("true output not low");
	a_out_invert: assert property (
		dio_pkg::dio_role_of(s_q.role, dio_pkg::PIN_TRIG) == dio_pkg::DIO_ROLE_OUTPUT
		&& !s_q.pwm_sel[dio_pkg::PIN_TRIG] && s_q.inv[dio_pkg::PIN_TRIG]
		|=> pin_o[dio_pkg::PIN_TRIG] == $past(s_q.lvl[dio_pkg::PIN_TRIG]))
		else $error("inverted output wrong");
	a_pwm_low: assert property (
		dio_pkg::dio_role_of(s_q.role, dio_pkg::PIN_TRIG) == dio_pkg::DIO_ROLE_OUTPUT
		&& s_q.pwm_sel[dio_pkg::PIN_TRIG] && !s_q.inv[dio_pkg::PIN_TRIG]
		|=> pin_o[dio_pkg::PIN_TRIG] == !$past(pwm_on))
		else $error("pwm level wrong");
	a_pwm_wrap: assert property (
		s_q.pwm_cnt + 32'h0000_0001 >= s_q.period |=> s_q.pwm_cnt == 32'h0000_0000)
		else $error("pwm counter overran its period");
	a_prot_level: assert property (
		is_default(s_q.role, dio_pkg::PIN_PFLAG) && !s_q.inv[dio_pkg::PIN_PFLAG]
		|=> pin_o[dio_pkg::PIN_PFLAG] == !$past(protection_flag_level))
		else $error("protection level wrong");
	a_on_level: assert property (
		is_default(s_q.role, dio_pkg::PIN_ONOFF) && !s_q.inv[dio_pkg::PIN_ONOFF]
		|=> pin_o[dio_pkg::PIN_ONOFF] == !$past(input_on))
		else $error("on state level wrong");
	a_inhibit_level: assert property (
		is_default(s_q.role, dio_pkg::PIN_INH)
		|=> emergency_inhibit == $past(edges.level[dio_pkg::PIN_INH]))
		else $error("inhibit level wrong");
	a_inhibit_cause: assert property (
		emergency_inhibit |-> $past(edges.level[dio_pkg::PIN_INH]))
		else $error("inhibit without valid level");
	a_clear_event: assert property (
		edges.fall[dio_pkg::PIN_PCLR] && protection_flag_level && !p1_busy
		&& is_default(s_q.role, dio_pkg::PIN_PCLR)
		|=> protection_clear_pulse ##1 !protection_clear_pulse)
		else $error("clear event missing");
	a_clear_refused: assert property (
		!protection_flag_level |=> !protection_clear_pulse)
		else $error("clear without protection");
	a_sync_events: assert property (
		edges.fall[dio_pkg::PIN_SOFF] && is_default(s_q.role, dio_pkg::PIN_SOFF)
		|=> sync_off_pulse)
		else $error("sync off event missing");
	a_sync_on: assert property (
		edges.fall[dio_pkg::PIN_SON] && is_default(s_q.role, dio_pkg::PIN_SON)
		|=> sync_on_pulse)
		else $error("sync on event missing");
	a_sync_on_single: assert property (
		sync_on_pulse |=> !sync_on_pulse)
		else $error("sync on event longer than one cycle");
	a_sync_off_single: assert property (
		sync_off_pulse |=> !sync_off_pulse)
		else $error("sync off event longer than one cycle");
	a_trig_gate: assert property (
		trigger_pulse |-> $past(s_q.trig_ext) && $past(edges.fall[dio_pkg::PIN_TRIG]))
		else $error("trigger without cause");
	a_trig_event: assert property (
		edges.fall[dio_pkg::PIN_TRIG] && s_q.trig_ext
		&& is_default(s_q.role, dio_pkg::PIN_TRIG)
		|=> trigger_pulse)
		else $error("trigger event missing");
	a_trig_refused: assert property (
		!s_q.trig_ext |=> !trigger_pulse)
		else $error("trigger while external source off");
	a_pulse_start: assert property (
		!p1_busy && on_rise && is_default(s_q.role, dio_pkg::PIN_PCLR)
		|=> p1_busy && s_q.p1_cnt == dio_pkg::PULSE_CNT_INIT ##1 pin_oe[dio_pkg::PIN_PCLR])
		else $error("turn-on pulse missing");
	// The two checks below pin the pulse length to the loaded count
	a_pulse_hold: assert property (
		p1_busy && s_q.p1_cnt != 16'h0000 |=> p1_busy)
		else $error("turn-on pulse cut short");
	a_pulse_end: assert property (
		p1_busy && s_q.p1_cnt == 16'h0000 |=> !p1_busy)
		else $error("turn-on pulse too long");
endmodule : dio_port
